// [hdl/gpio_bank.sv]
// one bidirectional bank: direction, data latch, pin drivers, read view
`timescale 1ns/1ps
module gpio_bank
  import lcd_ports_pkg::*;
#(
  parameter int         W        = 8,
  parameter logic [W-1:0] DIR_RST  = '0,
  parameter logic [W-1:0] DATA_RST = '0
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         dirWe,
  input  wire logic         dataWe,
  input  wire logic [W-1:0] wdata,
  input  wire bank_mode_t   mode,
  input  wire logic [W-1:0] pinSync,
  output logic      [W-1:0] readView,
  output logic      [W-1:0] pinOut,
  output logic      [W-1:0] pinOe
);

  logic [W-1:0] dir;
  logic [W-1:0] data;

  // write-only direction and read/write data latch
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dir  <= DIR_RST;
      data <= DATA_RST;
    end else begin
      if (dirWe) dir <= wdata;
      if (dataWe) data <= wdata;
    end
  end

  // drivers: off in standby, frozen in sleep-like modes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pinOut <= '0;
      pinOe  <= '0;
    end else if (mode.tristate) begin
      pinOe  <= '0;
    end else if (!mode.freeze) begin
      pinOut <= data;
      pinOe  <= dir;
    end
  end

  // outputs read the latch, inputs read the pin
  assign readView = (dir & data) | (~dir & pinSync);

endmodule

// [hdl/lcd_side_ports.sv]
// apb register slave for the two display-side ports and the input port
`timescale 1ns/1ps

// Summary of operation
// - eight-pin direction bit one drives pin
// - eight-pin direction resets to all inputs
// - eight-pin direction is write-only, reads ones
// - eight-pin pins float in reset, standby
// - four-pin port has bits three..zero only
// - four-pin read: latch if output, pin otherwise
// - four-pin data resets upper ones, lower zero
// - four-pin direction bit one drives pin
// - four-pin direction resets to all inputs
// - four-pin direction is write-only, reads ones
// - four-pin pins float, hold or work per mode
// - input port: eight pins, never driven
// - input port reads live pin levels
// - analog-selected input pin reads zero
// - reduced variant: input bits three..zero reserved
// - eight-pin read: latch if output, pin otherwise
// - eight-pin data resets to zero
module lcd_side_ports
  import lcd_ports_pkg::*;
#(
  parameter bit REDUCED = 1'b0
) (
  input  wire logic                mclk,
  input  wire logic                arst_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [DATA_W-1:0]   pwdata,
  output logic      [DATA_W-1:0]   prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire pmode_t              powerMode,
  input  wire logic                analogEnable,
  input  wire logic [3:0]          analogChannelSelect,
  input  wire logic [EIGHT_W-1:0]  eightPinIn,
  output logic      [EIGHT_W-1:0]  eightPinOut,
  output logic      [EIGHT_W-1:0]  eightPinOe,
  input  wire logic [FOUR_W-1:0]   fourPinIn,
  output logic      [FOUR_W-1:0]   fourPinOut,
  output logic      [FOUR_W-1:0]   fourPinOe,
  input  wire logic [INPUT_W-1:0]  inputPinIn
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic [EIGHT_W-1:0] eightSync;
  logic [FOUR_W-1:0]  fourSync;
  logic [INPUT_W-1:0] inputSync;
  logic [EIGHT_W-1:0] eightView;
  logic [FOUR_W-1:0]  fourView;
  logic [INPUT_W-1:0] inputView;
  logic [INPUT_W-1:0] analogMask;
  logic [REG_W-1:0]   regRead;
  bank_mode_t         eightMode;
  bank_mode_t         fourMode;
  logic               access;
  logic               commit;
  logic               wrCommit;
  logic               hitEightData;
  logic               hitFourData;
  logic               hitInputData;
  logic               hitEightDir;
  logic               hitFourDir;
  logic               hitAny;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // every pin input is foreign to mclk
  pin_sync #(.W(EIGHT_W)) eightSyncU (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .pinAsync (eightPinIn),
    .pinSync  (eightSync)
  );

  pin_sync #(.W(FOUR_W)) fourSyncU (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .pinAsync (fourPinIn),
    .pinSync  (fourSync)
  );

  pin_sync #(.W(INPUT_W)) inputSyncU (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .pinAsync (inputPinIn),
    .pinSync  (inputSync)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  // answer one cycle into the access phase, commit on that edge
  assign access       = psel & penable;
  assign commit       = access & pready;
  assign wrCommit     = commit & pwrite;
  assign hitEightData = (paddr == ADDR_EIGHT_DATA);
  assign hitFourData  = (paddr == ADDR_FOUR_DATA);
  assign hitInputData = (paddr == ADDR_INPUT_DATA);
  assign hitEightDir  = (paddr == ADDR_EIGHT_DIR);
  assign hitFourDir   = (paddr == ADDR_FOUR_DIR);
  assign hitAny       = hitEightData | hitFourData | hitInputData
                      | hitEightDir | hitFourDir;

  ////////////////////////////////////////////////////////////////////////
  // power modes to driver behaviour

  // eight-pin subsleep left open, so it holds like sleep
  assign eightMode.tristate = (powerMode == MODE_STANDBY);
  assign eightMode.freeze   = (powerMode == MODE_SLEEP)
                            | (powerMode == MODE_SUBSLEEP)
                            | (powerMode == MODE_WATCH);
  assign fourMode.tristate  = (powerMode == MODE_STANDBY);
  assign fourMode.freeze    = (powerMode == MODE_SLEEP)
                            | (powerMode == MODE_SUBSLEEP)
                            | (powerMode == MODE_WATCH);

  ////////////////////////////////////////////////////////////////////////
  // bidirectional banks

  gpio_bank #(
    .W        (EIGHT_W),
    .DIR_RST  (EIGHT_DIR_RST),
    .DATA_RST (EIGHT_DATA_RST)
  ) eightBank (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .dirWe    (wrCommit & hitEightDir),
    .dataWe   (wrCommit & hitEightData),
    .wdata    (pwdata[EIGHT_W-1:0]),
    .mode     (eightMode),
    .pinSync  (eightSync),
    .readView (eightView),
    .pinOut   (eightPinOut),
    .pinOe    (eightPinOe)
  );

  // only the low nibble exists; upper bits are never stored
  gpio_bank #(
    .W        (FOUR_W),
    .DIR_RST  (FOUR_DIR_RST[FOUR_W-1:0]),
    .DATA_RST (FOUR_DATA_RST[FOUR_W-1:0])
  ) fourBank (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .dirWe    (wrCommit & hitFourDir),
    .dataWe   (wrCommit & hitFourData),
    .wdata    (pwdata[FOUR_W-1:0]),
    .mode     (fourMode),
    .pinSync  (fourSync),
    .readView (fourView),
    .pinOut   (fourPinOut),
    .pinOe    (fourPinOe)
  );

  ////////////////////////////////////////////////////////////////////////
  // input-only port view

  // channel codes below four pick the shared analog pins
  genvar gi;
  generate
    for (gi = 0; gi < INPUT_W; gi++) begin : gMask
      if (gi < ANALOG_PINS) begin : gAn
        assign analogMask[gi] = analogEnable
          & (analogChannelSelect == 4'(gi));
      end else begin : gDig
        assign analogMask[gi] = 1'b0;
      end
    end
  endgenerate

  // live levels, analog channel forced low, reserved nibble zero
  assign inputView = REDUCED
    ? {inputSync[INPUT_W-1:ANALOG_PINS], RESERVED_READ}
    : (inputSync & ~analogMask);

  ////////////////////////////////////////////////////////////////////////
  // read mux

  // write-only registers hide their contents behind all ones
  assign regRead = hitEightData ? eightView
    : hitFourData  ? {FOUR_UPPER_READ, fourView}
    : hitInputData ? inputView
    : hitEightDir  ? WO_READ_VALUE
    : hitFourDir   ? WO_READ_VALUE
    : '0;

  ////////////////////////////////////////////////////////////////////////
  // apb answer

  // one wait state keeps the read path fully registered
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~hitAny;
      if (access & ~pready) begin
        prdata <= pwrite ? '0 : {{(DATA_W-REG_W){1'b0}}, regRead};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // helper: has software written the eight-pin direction yet
  logic dirEightWritten;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dirEightWritten <= 1'b0;
    end else if (wrCommit & hitEightDir) begin
      dirEightWritten <= 1'b1;
    end
  end

  sequence rdCommit(logic hit);
    commit && !pwrite && hit;
  endsequence

  sequence functional2;
    (powerMode == MODE_ACTIVE || powerMode == MODE_SUBACTIVE) [*2];
  endsequence

  sequence sleepy2;
    (fourMode.freeze && !fourMode.tristate) [*2];
  endsequence

  // eight-pin bank also holds through subsleep
  sequence eightHeld2;
    (eightMode.freeze && !eightMode.tristate) [*2];
  endsequence

  dir_reset_a: assert property (
    !dirEightWritten |-> eightPinOe == '0)
    else $error("eight-pin driver on before any direction write");

  dir8_read_a: assert property (
    rdCommit(hitEightDir) |-> prdata[REG_W-1:0] == WO_READ_VALUE)
    else $error("eight-pin direction read not all ones");

  dir4_read_a: assert property (
    rdCommit(hitFourDir) |-> prdata[REG_W-1:0] == WO_READ_VALUE)
    else $error("four-pin direction read not all ones");

  dir8_drive_a: assert property (
    (wrCommit && hitEightDir) ##0 functional2
      |=> eightPinOe == $past(pwdata[EIGHT_W-1:0], 2))
    else $error("eight-pin enables do not follow direction write");

  dir4_drive_a: assert property (
    (wrCommit && hitFourDir) ##0 functional2
      |=> fourPinOe == $past(pwdata[FOUR_W-1:0], 2))
    else $error("four-pin enables do not follow direction write");

  standby_float_a: assert property (
    powerMode == MODE_STANDBY |=> fourPinOe == '0 && eightPinOe == '0)
    else $error("pin driven in standby");

  sleep_hold_a: assert property (
    sleepy2 |-> $stable(fourPinOut) && $stable(fourPinOe))
    else $error("four-pin drivers moved while held");

  eight_hold_a: assert property (
    eightHeld2 |-> $stable(eightPinOut) && $stable(eightPinOe))
    else $error("eight-pin drivers moved while held");

  four_upper_a: assert property (
    rdCommit(hitFourData) |-> prdata[REG_W-1:FOUR_W] == FOUR_UPPER_READ)
    else $error("four-pin upper data bits not one");

  input_live_a: assert property (
    rdCommit(hitInputData) |-> prdata[REG_W-1:0] == $past(inputView))
    else $error("input port read not the sampled view");

  analog_zero_a: assert property (
    (access && !pready && !pwrite && hitInputData && analogEnable
      && analogChannelSelect < 4'(ANALOG_PINS))
      |=> prdata[analogChannelSelect] == 1'b0)
    else $error("analog-selected input bit not zero");

  reduced_low_a: assert property (
    (REDUCED && commit && !pwrite && hitInputData)
      |-> prdata[ANALOG_PINS-1:0] == RESERVED_READ)
    else $error("reserved input bits not zero");

  apb_answer_a: assert property (
    (access && !pready) |=> pready ##1 !pready)
    else $error("apb answer not a single cycle after one wait");

endmodule

// [hdl/pin_sync.sv]
// two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync
  import lcd_ports_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] pinAsync,
  output logic      [W-1:0] pinSync
);

  logic [W-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stage1  <= '0;
      pinSync <= '0;
    end else begin
      stage1  <= pinAsync;
      pinSync <= stage1;
    end
  end

endmodule

// [pkg/lcd_ports_pkg.sv]
// package: register map, reset values, modes and carriers for the ports
package lcd_ports_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_EIGHT_DATA = 16'hFFDC;
  localparam logic [15:0] IDX_FOUR_DATA  = 16'hFFDD;
  localparam logic [15:0] IDX_INPUT_DATA = 16'hFFDE;
  localparam logic [15:0] IDX_EIGHT_DIR  = 16'hFFEC;
  localparam logic [15:0] IDX_FOUR_DIR   = 16'hFFED;

  localparam int          ADDR_W = 18;
  localparam int          DATA_W = 32;
  localparam int          REG_W  = 8;

  localparam logic [ADDR_W-1:0] ADDR_EIGHT_DATA = {IDX_EIGHT_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_FOUR_DATA  = {IDX_FOUR_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_INPUT_DATA = {IDX_INPUT_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_EIGHT_DIR  = {IDX_EIGHT_DIR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_FOUR_DIR   = {IDX_FOUR_DIR, 2'b00};

  // widths and reset values
  localparam int          EIGHT_W         = 8;
  localparam int          FOUR_W          = 4;
  localparam int          INPUT_W         = 8;
  localparam int          ANALOG_PINS     = 4;
  localparam logic [7:0]  EIGHT_DATA_RST  = 8'h00;
  localparam logic [7:0]  EIGHT_DIR_RST   = 8'h00;
  localparam logic [7:0]  FOUR_DATA_RST   = 8'hF0;
  localparam logic [7:0]  FOUR_DIR_RST    = 8'hF0;
  localparam logic [7:0]  WO_READ_VALUE   = 8'hFF;
  localparam logic [3:0]  FOUR_UPPER_READ = 4'hF;
  localparam logic [3:0]  RESERVED_READ   = 4'h0;

  // operating mode as reported by the power controller
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_SUBACTIVE,
    MODE_SLEEP,
    MODE_SUBSLEEP,
    MODE_WATCH,
    MODE_STANDBY
  } pmode_t;

  // how a bidirectional bank treats its pin drivers
  typedef struct packed {
    logic freeze;
    logic tristate;
  } bank_mode_t;

endpackage

// [verif/pin_partner.sv]
// pin-side model: display controller and board drivers meeting the ports
`timescale 1ns/1ps
module pin_partner
  import lcd_ports_pkg::*;
(
  input  wire logic [EIGHT_W-1:0] eightOut,
  input  wire logic [EIGHT_W-1:0] eightOe,
  input  wire logic [EIGHT_W-1:0] eightDrv,
  output logic      [EIGHT_W-1:0] eightPin,
  input  wire logic [FOUR_W-1:0]  fourOut,
  input  wire logic [FOUR_W-1:0]  fourOe,
  input  wire logic [FOUR_W-1:0]  fourDrv,
  output logic      [FOUR_W-1:0]  fourPin,
  input  wire logic [INPUT_W-1:0] inputDrv,
  output logic      [INPUT_W-1:0] inputPin
);
  // wire level: the port wins where it drives, else the far side's driver
  assign eightPin = (eightOe & eightOut) | (~eightOe & eightDrv);
  assign fourPin  = (fourOe & fourOut) | (~fourOe & fourDrv);
  // input pins are only ever driven from outside
  assign inputPin = inputDrv;
endmodule

// [verif/test_lcd_side_ports.sv]
// self-checking bench for the display-side and input-only ports
`timescale 1ns/1ps
module test_lcd_side_ports;
  import lcd_ports_pkg::*;
  logic mclk, arst_n, psel, penable, pwrite, analogEnable, pready, pslverr;
  logic [ADDR_W-1:0]  paddr;
  logic [31:0]        pwdata, prdata, prdataR, q;
  logic [3:0]         analogChannelSelect, fourPinOut, fourPinOe, fourDrv;
  logic [3:0]         fourPinIn;
  logic [7:0]         eightPinOut, eightPinOe, eightDrv, eightPinIn;
  logic [7:0]         inputDrv, inputPinIn;
  pmode_t             powerMode;
  logic               err;
  int                 err_total, n_compared, cyc;

  //////////////////////////////////////////////////////////////////////////
  lcd_side_ports lcd_side_ports_inst (.mclk(mclk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerMode(powerMode), .analogEnable(analogEnable),
    .analogChannelSelect(analogChannelSelect), .eightPinIn(eightPinIn),
    .eightPinOut(eightPinOut), .eightPinOe(eightPinOe),
    .fourPinIn(fourPinIn), .fourPinOut(fourPinOut), .fourPinOe(fourPinOe),
    .inputPinIn(inputPinIn));
  // reduced variant shares the bus; only its read data is watched
  lcd_side_ports #(.REDUCED(1'b1)) lcd_side_ports_red_inst (.mclk(mclk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdataR), .pready(),
    .pslverr(), .powerMode(powerMode), .analogEnable(analogEnable),
    .analogChannelSelect(analogChannelSelect), .eightPinIn(eightPinIn),
    .eightPinOut(), .eightPinOe(), .fourPinIn(fourPinIn), .fourPinOut(),
    .fourPinOe(), .inputPinIn(inputPinIn));
  pin_partner pin_partner_inst (.eightOut(eightPinOut), .eightOe(eightPinOe),
    .eightDrv(eightDrv), .eightPin(eightPinIn), .fourOut(fourPinOut),
    .fourOe(fourPinOe), .fourDrv(fourDrv), .fourPin(fourPinIn),
    .inputDrv(inputDrv), .inputPin(inputPinIn));

  //////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the guard ceiling is far above the real run
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      final_report();
    end
  end

  task automatic final_report();
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one apb transfer; waits for pready, only the hang guard ends a wait
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // reset values and write-only reads
  task automatic t_reset();
    apb(1'b0, ADDR_EIGHT_DIR, 32'h0);
    chk(q, 32'h0000_00FF, "eight dir read");
    apb(1'b0, ADDR_FOUR_DIR, 32'h0);
    chk(q, 32'h0000_00FF, "four dir read");
    chk(eightPinOe, 8'h00, "eight oe reset");
    chk(fourPinOe, 4'h0, "four oe reset");
    apb(1'b0, ADDR_FOUR_DATA, 32'h0);
    chk(q, 32'h0000_00F5, "four pins as inputs");
    apb(1'b1, ADDR_EIGHT_DIR, 32'hFF);
    apb(1'b1, ADDR_FOUR_DIR, 32'h0F);
    apb(1'b0, ADDR_EIGHT_DATA, 32'h0);
    chk(q, 32'h0000_0000, "eight latch reset");
    apb(1'b0, ADDR_FOUR_DATA, 32'h0);
    chk(q, 32'h0000_00F0, "four latch reset");
  endtask

  // mixed directions on both bidirectional ports
  task automatic t_mixed();
    eightDrv <= 8'h3C;
    fourDrv <= 4'h8;
    apb(1'b1, ADDR_EIGHT_DIR, 32'h0F);
    apb(1'b1, ADDR_EIGHT_DATA, 32'hA5);
    apb(1'b1, ADDR_FOUR_DIR, 32'hF3);
    apb(1'b1, ADDR_FOUR_DATA, 32'hFE);
    tick(4);
    chk(eightPinOe, 8'h0F, "eight oe");
    chk(eightPinOut & 8'h0F, 8'h05, "eight out");
    chk(fourPinOe, 4'h3, "four oe");
    chk(fourPinOut & 4'h3, 4'h2, "four out");
    apb(1'b0, ADDR_EIGHT_DATA, 32'h0);
    chk(q, 32'h0000_0035, "eight read view");
    apb(1'b0, ADDR_FOUR_DATA, 32'h0);
    chk(q, 32'h0000_00FA, "four read view");
    apb(1'b0, ADDR_EIGHT_DIR, 32'h0);
    chk(q, 32'h0000_00FF, "eight dir still ones");
  endtask

  // input-only port, analog masking, reduced variant, unmapped address
  task automatic t_input();
    inputDrv <= 8'h9A;
    tick(4);
    apb(1'b1, ADDR_INPUT_DATA, 32'h00);
    apb(1'b0, ADDR_INPUT_DATA, 32'h0);
    chk(q, 32'h0000_009A, "input live");
    chk(prdataR, 32'h0000_0090, "reduced low bits");
    for (int k = 0; k < 4; k++) begin
      analogEnable <= 1'b1;
      analogChannelSelect <= 4'(k);
      apb(1'b0, ADDR_INPUT_DATA, 32'h0);
      chk(q, 32'h9A & ~(32'h1 << k), "analog pin zero");
    end
    analogEnable <= 1'b0;
    apb(1'b0, 18'h00000, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
  endtask

  // power modes: standby floats, sleep modes freeze, active resumes
  task automatic t_modes();
    apb(1'b1, ADDR_EIGHT_DIR, 32'hFF);
    apb(1'b1, ADDR_EIGHT_DATA, 32'h55);
    apb(1'b1, ADDR_FOUR_DIR, 32'h0F);
    apb(1'b1, ADDR_FOUR_DATA, 32'h06);
    powerMode <= MODE_STANDBY;
    tick(3);
    chk(eightPinOe, 8'h00, "eight standby");
    chk(fourPinOe, 4'h0, "four standby");
    powerMode <= MODE_SUBACTIVE;
    tick(3);
    chk(eightPinOut, 8'h55, "eight subactive");
    powerMode <= MODE_WATCH;
    tick(2);
    apb(1'b1, ADDR_EIGHT_DATA, 32'hAA);
    tick(3);
    chk(eightPinOut, 8'h55, "eight watch hold");
    powerMode <= MODE_SUBSLEEP;
    tick(2);
    apb(1'b1, ADDR_FOUR_DATA, 32'h09);
    tick(3);
    chk(fourPinOut, 4'h6, "four subsleep hold");
    chk(fourPinOe, 4'hF, "four subsleep oe");
    powerMode <= MODE_SLEEP;
    tick(2);
    apb(1'b1, ADDR_EIGHT_DATA, 32'h0F);
    apb(1'b1, ADDR_FOUR_DATA, 32'h03);
    tick(3);
    chk(eightPinOut, 8'h55, "eight sleep hold");
    chk(fourPinOut, 4'h6, "four sleep hold");
    powerMode <= MODE_ACTIVE;
    tick(3);
    chk(eightPinOut, 8'h0F, "eight active");
    chk(fourPinOut, 4'h3, "four active");
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    powerMode = MODE_ACTIVE;
    analogEnable = 1'b0;
    analogChannelSelect = 4'h0;
    eightDrv = 8'hC3;
    fourDrv = 4'h5;
    inputDrv = 8'h00;
    tick(15);
    chk(eightPinOe, 8'h00, "oe in reset");
    @(posedge mclk);
    arst_n <= 1'b1;
    tick(3);
    t_reset();
    t_mixed();
    t_input();
    t_modes();
    final_report();
  end
endmodule
